// *** verilog/rmi_defines.svh ***
/*
 Constants of the rotate-then-mask-insert unit: instruction field positions,
 opcodes, register offsets, reset values and field layouts.
 Assumes it is included by its bare name in files that need these values.
*/
`ifndef RMI_DEFINES_SVH
`define RMI_DEFINES_SVH

// *****************************************************************
// Instruction fields (vector index, bit 0 of the word is index 31)
// *****************************************************************
`define RMI_OPC_HI 31
`define RMI_OPC_LO 26
`define RMI_SRC_HI 25
`define RMI_SRC_LO 21
`define RMI_DST_HI 20
`define RMI_DST_LO 16
`define RMI_CNT_HI 15
`define RMI_CNT_LO 11
`define RMI_MB_HI 10
`define RMI_MB_LO 6
`define RMI_ME_HI 5
`define RMI_ME_LO 1
`define RMI_REC_BIT 0
`define RMI_CNT_REG_HI 4
`define RMI_CNT_REG_LO 0

// *****************************************************************
// Primary opcodes
// *****************************************************************
`define RMI_OP_REG_CNT 6'h16
`define RMI_OP_IMM_CNT 6'h14

// *****************************************************************
// Register map and layouts
// *****************************************************************
`define RMI_ADDR_W 8
`define RMI_REG_CTRL 8'h00
`define RMI_REG_STATUS 8'h04
`define RMI_REG_RESULT 8'h08
`define RMI_REG_COUNT 8'h0C
`define RMI_CTRL_LEGACY_BIT 0
`define RMI_STAT_ILL_BIT 0
`define RMI_STAT_CR0_HI 7
`define RMI_STAT_CR0_LO 4
`define RMI_CTRL_RESET 1'h1

`endif

// *** verilog/rmi_pkg.sv ***
/*
 Types of the rotate-then-mask-insert unit: issue and write-back carriers.
 Assumes the decoder and register file agree on these layouts.
*/
package rmi_pkg;

   // *****************************************************************
   // Condition field, most significant flag first
   // *****************************************************************
   typedef struct packed {
      logic less_than_flag;
      logic greater_than_flag;
      logic zero_result_flag;
      logic sum_ovf_flag;
   } cond_field_t;

   // *****************************************************************
   // Operands handed over by the decoder
   // *****************************************************************
   typedef struct packed {
      logic [31:0] instr;
      logic [31:0] source_reg;
      logic [31:0] target_reg;
      logic [31:0] count_reg;
      logic sum_ovf;
   } issue_t;

   // *****************************************************************
   // Write-back toward the register file
   // *****************************************************************
   typedef struct packed {
      logic [31:0] result;
      logic [4:0] dest_idx;
      logic dest_we;
      cond_field_t cond_field_zero;
      logic cond_we;
   } wb_t;

endpackage

// *** verilog/rmi_mask_gen.sv ***
/*
 Word mask generator: ones from mask_begin through mask_end, wrapping past
 position 31. Position 0 is the most significant bit of the mask.
 Assumes both positions are 5-bit values within one 32-bit word.
*/
`timescale 1ns/10ps
module rmi_mask_gen (
   input wire logic [4:0] i_mask_begin, // First position of the ones
   input wire logic [4:0] i_mask_end, // Last position of the ones
   output logic [31:0] o_mask // Generated mask
);

   logic [5:0] mb_ext;
   logic [5:0] me_inc;
   logic [5:0] pos;
   logic bit_on;

   // *****************************************************************
   // Mask build
   // *****************************************************************
   always_comb begin
      mb_ext = {1'h0, i_mask_begin};
      me_inc = {1'h0, i_mask_end} + 6'h01;
      pos = 6'h00;
      bit_on = 1'h0;
      o_mask = 32'h0000_0000;
      for (int p = 0; p < 32; p++) begin
         pos = 6'(p);
         if (mb_ext < me_inc) begin
            bit_on = (pos >= mb_ext) && (pos < me_inc);
         end else if (mb_ext == me_inc) begin
            bit_on = 1'h1;
         end else begin
            bit_on = !((pos >= me_inc) && (pos < mb_ext));
         end
         o_mask[31 - p] = bit_on;
      end
   end

endmodule

// *** verilog/rotate_mask_insert_unit.sv ***
/*
 Rotate-then-mask-insert execution unit for the register-count and the
 immediate-count word forms, with a small register file on a plain port.
 Assumes operands arrive from the decoder on this clock and that the
 write-back goes straight into the general register file.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "rmi_defines.svh"
module rotate_mask_insert_unit (
   input wire logic i_sys_clk, // System clock, 125 MHz
   input wire logic i_sys_rst, // Asynchronous reset, active high
   input wire logic i_clk_en, // Freezes all state while low
   input wire logic i_issue_valid, // Issue strobe from decoder
   input rmi_pkg::issue_t i_issue, // Instruction and operands
   output rmi_pkg::wb_t o_wb, // Write-back bundle
   output logic o_wb_valid, // Write-back strobe
   output logic o_illegal, // Illegal instruction pulse
   input wire logic [`RMI_ADDR_W-1:0] i_bus_addr, // Register byte address
   input wire logic [31:0] i_bus_wdata, // Register write data
   input wire logic i_bus_wr, // Register write strobe
   input wire logic i_bus_rd, // Register read strobe
   output logic [31:0] o_bus_rdata // Read data, cycle after strobe
);
   import rmi_pkg::*;

   // *****************************************************************
   // Helpers
   // *****************************************************************
   function automatic logic [31:0] rotl_f(input logic [31:0] val,
                                           input logic [4:0] amt);
      logic [63:0] dbl;
      dbl = {val, val} << amt;
      return dbl[63:32];
   endfunction

   function automatic logic [31:0] insert_f(input logic [31:0] rot,
                                             input logic [31:0] tgt,
                                             input logic [31:0] msk);
      return (rot & msk) | (tgt & ~msk);
   endfunction

   function automatic cond_field_t cond_f(input logic [31:0] res,
                                          input logic so);
      cond_field_t cf;
      cf.less_than_flag = res[31];
      cf.greater_than_flag = !res[31] && (res != 32'h0000_0000);
      cf.zero_result_flag = (res == 32'h0000_0000);
      cf.sum_ovf_flag = so;
      return cf;
   endfunction

   // *****************************************************************
   // Decode
   // *****************************************************************
   logic [5:0] opcode;
   logic [4:0] mask_begin;
   logic [4:0] mask_end;
   logic [4:0] rotate_amount;
   logic [4:0] reg_count;
   logic [4:0] dest_idx;
   logic record_flag;
   logic is_reg_cnt;
   logic is_imm_cnt;
   logic legal_op;
   logic illegal_op;
   logic legacy_en_ff;

   assign opcode = i_issue.instr[`RMI_OPC_HI:`RMI_OPC_LO];
   assign dest_idx = i_issue.instr[`RMI_DST_HI:`RMI_DST_LO];
   assign rotate_amount = i_issue.instr[`RMI_CNT_HI:`RMI_CNT_LO];
   assign mask_begin = i_issue.instr[`RMI_MB_HI:`RMI_MB_LO];
   assign mask_end = i_issue.instr[`RMI_ME_HI:`RMI_ME_LO];
   assign record_flag = i_issue.instr[`RMI_REC_BIT];
   assign reg_count = i_issue.count_reg[`RMI_CNT_REG_HI:`RMI_CNT_REG_LO];
   assign is_reg_cnt = (opcode == `RMI_OP_REG_CNT);
   assign is_imm_cnt = (opcode == `RMI_OP_IMM_CNT);
   // Legacy form only reaches write-back when the family is enabled
   assign legal_op = i_issue_valid && ((is_reg_cnt && legacy_en_ff) || is_imm_cnt);
   assign illegal_op = i_issue_valid && !legal_op;

   // *****************************************************************
   // Datapath
   // *****************************************************************
   logic [4:0] rot_amt;
   logic [31:0] rotated;
   logic [31:0] w_mask;
   logic [31:0] merged;
   cond_field_t cond_calc;

   assign rot_amt = is_reg_cnt ? reg_count : rotate_amount;
   assign rotated = rotl_f(i_issue.source_reg, rot_amt);
   assign merged = insert_f(rotated, i_issue.target_reg, w_mask);
   // Summary overflow is only read here; nothing drives the exception register
   assign cond_calc = cond_f(merged, i_issue.sum_ovf);

   rmi_mask_gen u_mask_gen (
      .i_mask_begin(mask_begin),
      .i_mask_end(mask_end),
      .o_mask(w_mask)
   );

   // *****************************************************************
   // Write-back stage
   // *****************************************************************
   wb_t wb_ff;
   logic wb_valid_ff;
   logic illegal_ff;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wb_valid_ff <= 1'h0;
         illegal_ff <= 1'h0;
      end else if (i_clk_en) begin
         wb_valid_ff <= legal_op;
         illegal_ff <= illegal_op;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wb_ff.result <= 32'h0000_0000;
         wb_ff.dest_idx <= 5'h00;
         wb_ff.dest_we <= 1'h0;
      end else if (i_clk_en) begin
         wb_ff.dest_we <= legal_op;
         if (legal_op) begin
            wb_ff.result <= merged;
            wb_ff.dest_idx <= dest_idx;
         end
      end
   end

   // Condition field holds its value unless a recording form completes
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wb_ff.cond_field_zero <= 4'h0;
         wb_ff.cond_we <= 1'h0;
      end else if (i_clk_en) begin
         wb_ff.cond_we <= legal_op && record_flag;
         if (legal_op && record_flag) begin
            wb_ff.cond_field_zero <= cond_calc;
         end
      end
   end

   assign o_wb = wb_ff;
   assign o_wb_valid = wb_valid_ff;
   assign o_illegal = illegal_ff;

   // *****************************************************************
   // Software registers
   // *****************************************************************
   logic wr_ctrl;
   logic wr_status;
   logic ill_seen_ff;
   logic [31:0] op_count_ff;
   logic [31:0] rdata_ff;
   logic [31:0] rd_mux;

   assign wr_ctrl = i_bus_wr && (i_bus_addr == `RMI_REG_CTRL);
   assign wr_status = i_bus_wr && (i_bus_addr == `RMI_REG_STATUS);

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         legacy_en_ff <= `RMI_CTRL_RESET;
      end else if (i_clk_en && wr_ctrl) begin
         legacy_en_ff <= i_bus_wdata[`RMI_CTRL_LEGACY_BIT];
      end
   end

   // Sticky illegal flag, write one to clear; a new event beats the clear
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ill_seen_ff <= 1'h0;
      end else if (i_clk_en) begin
         if (illegal_op) begin
            ill_seen_ff <= 1'h1;
         end else if (wr_status && i_bus_wdata[`RMI_STAT_ILL_BIT]) begin
            ill_seen_ff <= 1'h0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         op_count_ff <= 32'h0000_0000;
      end else if (i_clk_en && legal_op) begin
         op_count_ff <= op_count_ff + 32'h0000_0001;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_bus_addr)
         `RMI_REG_CTRL: begin
            rd_mux[`RMI_CTRL_LEGACY_BIT] = legacy_en_ff;
         end
         `RMI_REG_STATUS: begin
            rd_mux[`RMI_STAT_ILL_BIT] = ill_seen_ff;
            rd_mux[`RMI_STAT_CR0_HI:`RMI_STAT_CR0_LO] = wb_ff.cond_field_zero;
         end
         `RMI_REG_RESULT: begin
            rd_mux = wb_ff.result;
         end
         `RMI_REG_COUNT: begin
            rd_mux = op_count_ff;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Read data stands for one cycle after each strobe cycle, longer while i_clk_en is low
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (i_clk_en) begin
         rdata_ff <= i_bus_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign o_bus_rdata = rdata_ff;

   // *****************************************************************
   // Checks
   // *****************************************************************
   logic [5:0] chk_mb;
   logic [5:0] chk_me_inc;
   assign chk_mb = {1'h0, mask_begin};
   assign chk_me_inc = {1'h0, mask_end} + 6'h01;

   reg_count_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && legal_op && is_reg_cnt) |=>
      (o_wb.result == (((($past(i_issue.source_reg) << $past(i_issue.count_reg[4:0])) |
         ($past(i_issue.source_reg) >> (6'h20 - $past(i_issue.count_reg[4:0])))) &
         $past(w_mask)) | ($past(i_issue.target_reg) & ~$past(w_mask)))))
      else $error("register-count rotate amount wrong");

   imm_count_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && legal_op && is_imm_cnt) |=>
      (o_wb.result == (((($past(i_issue.source_reg) << $past(i_issue.instr[15:11])) |
         ($past(i_issue.source_reg) >> (6'h20 - $past(i_issue.instr[15:11])))) &
         $past(w_mask)) | ($past(i_issue.target_reg) & ~$past(w_mask)))))
      else $error("immediate rotate amount wrong");

   keep_target_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && legal_op) |=> o_wb.dest_we && o_wb_valid &&
      ((o_wb.result & ~$past(w_mask)) == ($past(i_issue.target_reg) & ~$past(w_mask))))
      else $error("unmasked target bits changed");

   mask_range_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (chk_mb < chk_me_inc) |->
      (w_mask == ((32'hFFFF_FFFF >> mask_begin) & (32'hFFFF_FFFF << (5'h1F - mask_end)))))
      else $error("plain mask range wrong");

   mask_full_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (chk_mb == chk_me_inc) |-> (w_mask == 32'hFFFF_FFFF))
      else $error("full mask not all ones");

   mask_wrap_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (chk_mb > chk_me_inc) |->
      (~w_mask == ((32'hFFFF_FFFF >> chk_me_inc) & (32'hFFFF_FFFF << (6'h20 - chk_mb)))))
      else $error("wrap-around mask wrong");

   cond_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && !(legal_op && record_flag)) |=>
      !o_wb.cond_we && $stable(o_wb.cond_field_zero))
      else $error("condition field changed without record");

   so_source_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && legal_op && record_flag) |=>
      o_wb.cond_we && (o_wb.cond_field_zero.sum_ovf_flag == $past(i_issue.sum_ovf)))
      else $error("summary overflow not copied");

   legacy_gate_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && i_issue_valid && is_reg_cnt && !legacy_en_ff) |=>
      o_illegal && !o_wb_valid && !o_wb.dest_we)
      else $error("legacy form accepted while disabled");

   word_rotate_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (chk_mb == chk_me_inc) |->
      (merged == {rotated[31:0]}) && (rotated[0] == i_issue.source_reg[5'h00 - rot_amt]))
      else $error("word rotate wrong");

   dest_field_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && legal_op) |=> (o_wb.dest_idx == $past(i_issue.instr[20:16])))
      else $error("destination field wrong");

   sign_flags_a: assert property (
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_clk_en && legal_op && record_flag) |=>
      (o_wb.cond_field_zero.less_than_flag == o_wb.result[31]) &&
      (o_wb.cond_field_zero.zero_result_flag == (o_wb.result == 32'h0000_0000)) &&
      ($countones(o_wb.cond_field_zero[3:1]) == 1))
      else $error("sign flags wrong");

endmodule

// *** sim/rmi_regfile_model.sv ***
/*
 Behavioural decoder and general register file facing the insert unit.
 Assumes the bench hands it one instruction word per request strobe.
*/
`timescale 1ns/10ps
module rmi_regfile_model (
   input wire logic i_sys_clk, // System clock
   input wire logic i_sys_rst, // Reset, active high
   input wire logic i_req_valid, // Instruction request from bench
   input wire logic [31:0] i_req_instr, // Instruction word
   input wire logic i_req_so, // Summary-overflow bit to hand over
   input rmi_pkg::wb_t i_wb, // Write-back from the unit
   output logic o_issue_valid, // Issue strobe toward the unit
   output rmi_pkg::issue_t o_issue // Operands toward the unit
);
   import rmi_pkg::*;
   logic [31:0] general_register [32];
   // Operand lines toggle between issues so a stale value never passes
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_issue_valid <= 1'b0;
         o_issue <= '0;
      end else begin
         o_issue_valid <= i_req_valid;
         if (i_req_valid) begin
            o_issue.instr <= i_req_instr;
            o_issue.source_reg <= general_register[i_req_instr[25:21]];
            o_issue.target_reg <= general_register[i_req_instr[20:16]];
            o_issue.count_reg <= general_register[i_req_instr[15:11]];
            o_issue.sum_ovf <= i_req_so;
         end else begin
            o_issue <= ~o_issue;
         end
      end
   end
   always @(posedge i_sys_clk) begin
      if (i_wb.dest_we === 1'b1) begin
         general_register[i_wb.dest_idx] <= i_wb.result;
      end
   end
endmodule

// *** sim/rotate_mask_insert_unit_test.sv ***
/*
 Self-checking bench of the insert unit: reference model, register-file
 partner and plain-port register accesses.
 Assumes the design, its package and rmi_defines.svh are compiled first.
*/
`timescale 1ns/10ps
`include "rmi_defines.svh"
module rotate_mask_insert_unit_test;
   import rmi_pkg::*;
   typedef struct {
      bit ill;
      logic [31:0] res;
      logic [4:0] dst;
      bit rec;
      logic [3:0] cond;
   } exp_t;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_clk_en = 1'b1;
   logic req_valid = 1'b0;
   logic [31:0] req_instr = '0;
   logic req_so = 1'b0;
   logic [7:0] bus_addr = '0;
   logic [31:0] bus_wdata = '0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic issue_valid;
   issue_t issue;
   wb_t wb;
   logic wb_valid;
   logic illegal;
   logic [31:0] bus_rdata;
   int num_errors = 0;
   int num_checks = 0;
   logic [31:0] rng = 32'h0000_0025;
   logic [31:0] m_gpr [32];
   logic [31:0] m_res = '0;
   logic [3:0] m_cond = '0;
   logic m_legacy = 1'b1;
   logic m_ill = 1'b0;
   logic [31:0] m_count = '0;
   exp_t exp_q [$];
   exp_t cur;
   int mbs [7] = '{0, 5, 20, 7, 31, 31, 16};
   int mes [7] = '{31, 4, 3, 7, 30, 0, 15};

   rotate_mask_insert_unit dut (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_issue_valid(issue_valid), .i_issue(issue), .o_wb(wb), .o_wb_valid(wb_valid),
      .o_illegal(illegal), .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata),
      .i_bus_wr(bus_wr), .i_bus_rd(bus_rd), .o_bus_rdata(bus_rdata)
   );
   rmi_regfile_model u_partner (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_req_valid(req_valid),
      .i_req_instr(req_instr), .i_req_so(req_so), .i_wb(wb),
      .o_issue_valid(issue_valid), .o_issue(issue)
   );

   initial begin
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #400_000;
      num_errors++;
      print_verdict();
   end

   // *****************************************************************
   // Helpers
   // *****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Position 0 is the most significant bit
   function automatic logic [31:0] mk_mask(input int mb, input int me);
      logic [31:0] m;
      for (int p = 0; p < 32; p++) begin
         m[31-p] = (mb <= me) ? (p >= mb && p <= me) : !(p > me && p < mb);
      end
      return m;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      num_checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic bus_write(input logic [7:0] a, input logic [31:0] dv);
      @(posedge i_sys_clk);
      bus_addr <= a;
      bus_wdata <= dv;
      bus_wr <= 1'b1;
      @(posedge i_sys_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic bus_read(input logic [7:0] a, output logic [31:0] dv);
      @(posedge i_sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge i_sys_clk);
      bus_rd <= 1'b0;
      #1;
      dv = bus_rdata;
   endtask
   task automatic set_reg(input int i, input logic [31:0] v);
      @(posedge i_sys_clk);
      u_partner.general_register[i] <= v;
      m_gpr[i] = v;
   endtask
   task automatic do_op(input logic [5:0] opc, input logic [4:0] s, d, c, mb, me,
                        input logic rc, input logic so, input int gap);
      logic [31:0] rot;
      logic [31:0] m;
      logic [4:0] amt;
      exp_t e;
      e.ill = !(opc == `RMI_OP_IMM_CNT || (opc == `RMI_OP_REG_CNT && m_legacy));
      amt = (opc == `RMI_OP_REG_CNT) ? m_gpr[c][4:0] : c;
      rot = (m_gpr[s] << amt) | (m_gpr[s] >> (32 - amt));
      m = mk_mask(mb, me);
      e.res = (rot & m) | (m_gpr[d] & ~m);
      e.dst = d;
      e.rec = rc;
      e.cond = m_cond;
      if (!e.ill) begin
         if (rc) begin
            e.cond = {e.res[31], !e.res[31] && e.res != 0, e.res == 0, so};
         end
         m_gpr[d] = e.res;
         m_res = e.res;
         m_cond = e.cond;
         m_count++;
      end else begin
         m_ill = 1'b1;
      end
      exp_q.push_back(e);
      @(posedge i_sys_clk);
      req_valid <= 1'b1;
      req_instr <= {opc, s, d, c, mb, me, rc};
      req_so <= so;
      repeat (gap) begin
         @(posedge i_sys_clk);
         req_valid <= 1'b0;
      end
   endtask

   // *****************************************************************
   // Write-back monitor
   // *****************************************************************
   always @(posedge i_sys_clk) begin
      #1;
      if (wb_valid === 1'b1 || illegal === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(32'({wb_valid, illegal}), 32'h0000_0000);
         end else begin
            cur = exp_q.pop_front();
            check(illegal, cur.ill);
            check(wb.dest_we, !cur.ill);
            if (!cur.ill) begin
               check(wb.result, cur.res);
               check(wb.dest_idx, cur.dst);
               check(wb.cond_we, cur.rec);
               check(wb.cond_field_zero, cur.cond);
            end
         end
      end
   end

   // *****************************************************************
   // Main sequence
   // *****************************************************************
   initial begin
      logic [31:0] v;
      logic [5:0] opc;
      repeat (5) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      for (int a = 0; a < 20; a += 4) begin
         bus_read(8'(a), v);
         check(v, (a == 0) ? 32'h0000_0001 : 32'h0000_0000);
      end
      $display("test reset_values done");
      @(posedge i_sys_clk);
      for (int i = 0; i < 32; i++) begin
         rng = lfsr(rng);
         m_gpr[i] = rng;
         u_partner.general_register[i] <= rng;
      end
      set_reg(4, 32'h9000_3000);
      set_reg(5, 32'h0000_0002);
      set_reg(6, 32'hFFFF_FFFF);
      do_op(`RMI_OP_REG_CNT, 5'h04, 5'h06, 5'h05, 5'h00, 5'h1D, 1'b0, 1'b1, 3);
      bus_read(`RMI_REG_RESULT, v);
      check(v, 32'h4000_C003);
      set_reg(4, 32'hB004_3000);
      set_reg(5, 32'hFFFF_FFE2);
      set_reg(6, 32'hFFFF_FFFF);
      do_op(`RMI_OP_REG_CNT, 5'h04, 5'h06, 5'h05, 5'h00, 5'h1D, 1'b1, 1'b0, 3);
      bus_read(`RMI_REG_RESULT, v);
      check(v, 32'hC010_C003);
      bus_read(`RMI_REG_STATUS, v);
      check(v, 32'h0000_0080);
      do_op(`RMI_OP_IMM_CNT, 5'h04, 5'h06, 5'h02, 5'h00, 5'h1D, 1'b0, 1'b1, 3);
      bus_read(`RMI_REG_RESULT, v);
      check(v, 32'hC010_C003);
      $display("test examples done");
      for (int i = 0; i < 7; i++) begin
         rng = lfsr(rng);
         do_op(`RMI_OP_IMM_CNT, rng[4:0], rng[9:5], rng[14:10], 5'(mbs[i]), 5'(mes[i]),
               1'b1, rng[15], 3);
      end
      $display("test mask_table done");
      for (int i = 0; i < 60; i++) begin
         rng = lfsr(rng);
         opc = (rng[4:1] == 4'h0) ? rng[10:5] : (rng[0] ? `RMI_OP_REG_CNT : `RMI_OP_IMM_CNT);
         do_op(opc, rng[15:11], rng[20:16], rng[25:21], rng[30:26], rng[9:5], rng[31],
               rng[6], 3);
      end
      for (int i = 0; i < 4; i++) begin
         rng = lfsr(rng);
         do_op(i[0] ? `RMI_OP_REG_CNT : `RMI_OP_IMM_CNT, 5'(8 + i), 5'(16 + i), 5'(24 + i),
               rng[4:0], rng[9:5], 1'b1, rng[10], (i == 3) ? 3 : 0);
      end
      $display("test random_and_burst done");
      do_op(6'h15, 5'h01, 5'h02, 5'h03, 5'h00, 5'h1F, 1'b1, 1'b0, 3);
      bus_read(`RMI_REG_STATUS, v);
      check(v, {24'h00_0000, m_cond, 3'h0, m_ill});
      bus_write(`RMI_REG_STATUS, 32'h0000_0001);
      m_ill = 1'b0;
      bus_write(`RMI_REG_CTRL, 32'h0000_0000);
      m_legacy = 1'b0;
      do_op(`RMI_OP_REG_CNT, 5'h01, 5'h02, 5'h03, 5'h00, 5'h1F, 1'b1, 1'b0, 3);
      do_op(`RMI_OP_IMM_CNT, 5'h01, 5'h02, 5'h03, 5'h04, 5'h02, 1'b0, 1'b0, 3);
      bus_write(`RMI_REG_CTRL, 32'h0000_0001);
      m_legacy = 1'b1;
      do_op(`RMI_OP_REG_CNT, 5'h02, 5'h01, 5'h03, 5'h1F, 5'h00, 1'b1, 1'b1, 3);
      bus_read(`RMI_REG_STATUS, v);
      check(v, {24'h00_0000, m_cond, 3'h0, 1'b1});
      $display("test illegal_and_legacy done");
      @(posedge i_sys_clk);
      i_clk_en <= 1'b0;
      req_valid <= 1'b1;
      req_instr <= {`RMI_OP_IMM_CNT, 5'h01, 5'h02, 5'h03, 5'h00, 5'h1F, 1'b1};
      @(posedge i_sys_clk);
      req_valid <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      i_clk_en <= 1'b1;
      bus_read(`RMI_REG_RESULT, v);
      check(v, m_res);
      $display("test clock_enable done");
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
         @(posedge i_sys_clk);
      end
      check(32'(exp_q.size()), 32'h0000_0000);
      bus_read(`RMI_REG_COUNT, v);
      check(v, m_count);
      for (int i = 0; i < 32; i++) begin
         check(u_partner.general_register[i], m_gpr[i]);
      end
      $display("test final_state done");
      print_verdict();
   end
endmodule
